// >>> verilog/vfm_top.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
`include "vfm_defines.svh"

// Contract
// RULE_01: Valve type single, double or directional selects used signals.
// RULE_02: Switch-on limit 50 ms to 10 s in 10 ms steps; zero disables.
// RULE_03: Switch-off limit 50 ms to 10 s in 10 ms steps; zero disables.
// RULE_04: Software disables continuous monitoring when switch-on limit is zero.
// RULE_05: Software keeps nonzero limits above the evaluation period.
// RULE_06: Output rises only on control rising while read-back is high.
// RULE_07: Output low when control low or any error pending.
// RULE_08: Output 1 follows control 1; output 2 by valve type.
// RULE_09: Control rising with read-back low raises read-back error.
// RULE_10: Read-back not falling within switch-on limit raises error.
// RULE_11: Read-back not rising within switch-off limit raises error.
// RULE_12: Continuous monitoring: read-back high while control high is error.
// RULE_13: Directional type: both controls high raises directional error.
// RULE_14: Error flag is high while either error is high; code also needs ctrl bit VFM_CTRL_USE_FLAG set.
// RULE_15: Errors clear when enabled controls low and read-backs high.
// RULE_16: Manual reset also needs a valid reset pulse to clear.
// RULE_17: Valid reset pulse 100 or 350 ms minimum, 30 s maximum.
// RULE_18: Inputs evaluated each cycle; timing counted in 10 ms ticks.
module vfm_top
    import vfm_pkg::*;
#(
    parameter int TICK_CYC = `VFM_TICK_CYC
) (
    // Clock and reset.
    input  wire logic            pclk,
    input  wire logic            presetn,
    // APB slave.
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Valve pins.
    input  wire vfm_pkg::vfm_in_t  pins_in,
    output vfm_pkg::vfm_out_t      pins_out,
    // Interrupt.
    output logic                 irq
);
    import vfm_pkg::*;

    // ------------------------------------------------------------------
    // Register bus.
    // ------------------------------------------------------------------
    logic [5:0]  ctrl_q;
    logic [9:0]  ton_q;
    logic [9:0]  toff_q;
    logic [2:0]  istat_q;
    logic [2:0]  imask_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        acc;
    logic        rd_istat;
    logic [2:0]  ev;
    vfm_out_t    out_q;

    function automatic logic known(input logic [11:0] a);
        known = (a == `VFM_ADDR_CTRL) || (a == `VFM_ADDR_TON) ||
                (a == `VFM_ADDR_TOFF) || (a == `VFM_ADDR_STATUS) ||
                (a == `VFM_ADDR_IRQ_STAT) || (a == `VFM_ADDR_IRQ_MASK);
    endfunction : known

    assign acc      = psel && penable && !pready_q;
    assign rd_istat = acc && !pwrite && (paddr == `VFM_ADDR_IRQ_STAT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= `VFM_CTRL_RESET;
            ton_q   <= `VFM_TON_RESET;
            toff_q  <= `VFM_TOFF_RESET;
            imask_q <= 3'h0;
        end else if (psel && penable && pready_q && pwrite) begin
            case (paddr)
                `VFM_ADDR_CTRL:     ctrl_q  <= pwdata[5:0];
                `VFM_ADDR_TON:      ton_q   <= pwdata[9:0];
                `VFM_ADDR_TOFF:     toff_q  <= pwdata[9:0];
                `VFM_ADDR_IRQ_MASK: imask_q <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc && !known(paddr);
            prdata_q  <= 32'h0;
            if (acc && !pwrite) begin
                case (paddr)
                    `VFM_ADDR_CTRL:     prdata_q <= {26'h0, ctrl_q};
                    `VFM_ADDR_TON:      prdata_q <= {22'h0, ton_q};
                    `VFM_ADDR_TOFF:     prdata_q <= {22'h0, toff_q};
                    `VFM_ADDR_STATUS:   prdata_q <= {27'h0, out_q};
                    `VFM_ADDR_IRQ_STAT: prdata_q <= {29'h0, istat_q};
                    `VFM_ADDR_IRQ_MASK: prdata_q <= {29'h0, imask_q};
                    default:            prdata_q <= 32'h0;
                endcase
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------------
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic [4:0] s3_q;
    logic [4:0] in_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 5'h0;
            s2_q <= 5'h0;
            s3_q <= 5'h0;
            in_q <= 5'h0;
        end else begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < 5; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    in_q[i] <= s3_q[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Tick generator.
    // ------------------------------------------------------------------
    logic [19:0] pre_q;
    logic        tick;

    assign tick = (pre_q == 20'(TICK_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin // RULE_18
        if (!presetn) begin
            pre_q <= 20'h0;
        end else if (tick) begin
            pre_q <= 20'h0;
        end else begin
            pre_q <= pre_q + 20'h1;
        end
    end

    // ------------------------------------------------------------------
    // Valve evaluation.
    // ------------------------------------------------------------------
    vfm_type_t vtype;
    logic      c1, c2, r1, r2, rs;
    logic      en2, ctl2_eff, dir_mode;
    logic      c1_q, c2_q, rs_q;
    logic      rise1, rise2, fall1, fall2;
    logic [9:0] on1_q, on2_q, off1_q, off2_q;
    logic      onw1_q, onw2_q, offw1_q, offw2_q;
    logic      rb_err_q, dir_err_q;
    logic      set_rb, set_dir, clr_ok, pulse_ok;
    logic [11:0] rp_q;
    logic      rp_ovf_q;

    assign vtype    = vfm_type_t'(ctrl_q[1:0]);
    assign {c1, c2, r1, r2, rs} = in_q;
    assign dir_mode = (vtype == VFM_DIRECTIONAL);
    assign en2      = (vtype != VFM_SINGLE); // RULE_01
    assign ctl2_eff = dir_mode ? c1 : (vtype == VFM_DOUBLE) && c2; // RULE_08
    assign rise1    = c1 && !c1_q;
    assign fall1    = !c1 && c1_q;
    assign rise2    = ctl2_eff && !c2_q;
    assign fall2    = !ctl2_eff && c2_q;

    function automatic logic expired(input logic [9:0] cnt,
                                     input logic [9:0] lim);
        expired = (lim != 10'h0) && (cnt >= lim);
    endfunction : expired

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1_q <= 1'b0;
            c2_q <= 1'b0;
            rs_q <= 1'b0;
        end else begin
            c1_q <= c1;
            c2_q <= ctl2_eff;
            rs_q <= rs;
        end
    end

    // Feedback windows: counters run from a control edge until the
    // read-back answers with the inverted level.
    always_ff @(posedge pclk or negedge presetn) begin // RULE_02 RULE_03
        if (!presetn) begin
            onw1_q  <= 1'b0;
            onw2_q  <= 1'b0;
            offw1_q <= 1'b0;
            offw2_q <= 1'b0;
            on1_q   <= 10'h0;
            on2_q   <= 10'h0;
            off1_q  <= 10'h0;
            off2_q  <= 10'h0;
        end else begin
            onw1_q  <= rise1 ? 1'b1 : (onw1_q && c1 && r1 && !set_rb);
            onw2_q  <= rise2 ? en2 : (onw2_q && ctl2_eff && r2 && !set_rb);
            offw1_q <= fall1 ? 1'b1 : (offw1_q && !c1 && !r1 && !set_rb);
            offw2_q <= fall2 ? en2 : (offw2_q && !ctl2_eff && !r2 && !set_rb);
            on1_q   <= rise1 ? 10'h0 : on1_q + {9'h0, tick && onw1_q};
            on2_q   <= rise2 ? 10'h0 : on2_q + {9'h0, tick && onw2_q};
            off1_q  <= fall1 ? 10'h0 : off1_q + {9'h0, tick && offw1_q};
            off2_q  <= fall2 ? 10'h0 : off2_q + {9'h0, tick && offw2_q};
        end
    end

    always_comb begin
        set_rb = 1'b0;
        if ((rise1 && !r1) || (en2 && rise2 && !r2)) begin
            set_rb = 1'b1; // RULE_09
        end
        if ((onw1_q && expired(on1_q, ton_q)) ||
            (onw2_q && expired(on2_q, ton_q))) begin
            set_rb = 1'b1; // RULE_10
        end
        if ((offw1_q && expired(off1_q, toff_q)) ||
            (offw2_q && expired(off2_q, toff_q))) begin
            set_rb = 1'b1; // RULE_11
        end
        if (ctrl_q[`VFM_CTRL_CONT] && !onw1_q && c1_q && c1 && r1 &&
            !rise1) begin
            set_rb = 1'b1; // RULE_12
        end
        if (ctrl_q[`VFM_CTRL_CONT] && en2 && !onw2_q && c2_q && ctl2_eff &&
            r2 && !rise2) begin
            set_rb = 1'b1; // RULE_12
        end
    end

    assign set_dir = dir_mode && c1 && c2; // RULE_13

    // Reset pulse width measured in 10 ms ticks.
    always_ff @(posedge pclk or negedge presetn) begin // RULE_17
        if (!presetn) begin
            rp_q     <= 12'h0;
            rp_ovf_q <= 1'b0;
        end else if (!rs) begin
            rp_q     <= 12'h0;
            rp_ovf_q <= 1'b0;
        end else if (tick) begin
            if (rp_q == 12'(`VFM_RST_MAX_MS / `VFM_STEP_MS)) begin
                rp_ovf_q <= 1'b1;
            end else begin
                rp_q <= rp_q + 12'h1;
            end
        end
    end

    assign pulse_ok = rs_q && !rs && !rp_ovf_q &&
        (rp_q >= (ctrl_q[`VFM_CTRL_LONG_RST] ?
                  12'(`VFM_RST_LONG_MS / `VFM_STEP_MS) :
                  12'(`VFM_RST_SHORT_MS / `VFM_STEP_MS))); // RULE_17

    assign clr_ok = !c1 && r1 && (!en2 || (!c2 && r2)) &&
        (!ctrl_q[`VFM_CTRL_MANUAL] || pulse_ok); // RULE_15 RULE_16

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_err_q  <= 1'b0;
            dir_err_q <= 1'b0;
        end else begin
            rb_err_q  <= set_rb || (rb_err_q && !clr_ok); // RULE_15
            dir_err_q <= set_dir || (dir_err_q && !clr_ok); // RULE_15
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '0;
        end else begin
            out_q.rb_err   <= rb_err_q;
            out_q.dir_err  <= dir_err_q;
            out_q.err_flag <= ctrl_q[`VFM_CTRL_USE_FLAG] &&
                              (rb_err_q || dir_err_q); // RULE_14
            if (!c1 || rb_err_q || dir_err_q || set_rb || set_dir) begin
                out_q.out1 <= 1'b0; // RULE_07
            end else if (rise1 && r1) begin
                out_q.out1 <= 1'b1; // RULE_06
            end
            if (!en2 || !ctl2_eff || rb_err_q || dir_err_q || set_rb ||
                set_dir) begin
                out_q.out2 <= 1'b0; // RULE_07
            end else if (rise2 && r2) begin
                out_q.out2 <= 1'b1; // RULE_06 RULE_08
            end
        end
    end

    assign pins_out = out_q;

    // ------------------------------------------------------------------
    // Interrupts.
    // ------------------------------------------------------------------
    assign ev = {set_dir && !dir_err_q, set_rb && !rb_err_q,
                 clr_ok && (rb_err_q || dir_err_q)};

    logic irq_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= 3'h0;
            irq_q   <= 1'b0;
        end else begin
            istat_q <= ev | (rd_istat ? 3'h0 : istat_q);
            irq_q   <= |((ev | (rd_istat ? 3'h0 : istat_q)) & imask_q);
        end
    end

    assign irq = irq_q;

endmodule : vfm_top

// >>> common/vfm_defines.svh
`ifndef VFM_DEFINES_SVH
`define VFM_DEFINES_SVH

`define VFM_ADDR_CTRL      12'h000
`define VFM_ADDR_TON       12'h004
`define VFM_ADDR_TOFF      12'h008
`define VFM_ADDR_STATUS    12'h00C
`define VFM_ADDR_IRQ_STAT  12'h010
`define VFM_ADDR_IRQ_MASK  12'h014

`define VFM_CTRL_TYPE_LSB  0
`define VFM_CTRL_MANUAL    2
`define VFM_CTRL_CONT      3
`define VFM_CTRL_LONG_RST  4
`define VFM_CTRL_USE_FLAG  5
`define VFM_CTRL_RESET     6'h20

`define VFM_TON_RESET      10'h005
`define VFM_TOFF_RESET     10'h005

`define VFM_TICK_NS        10000000
`define VFM_CLK_NS         10
`define VFM_TICK_CYC       (`VFM_TICK_NS / `VFM_CLK_NS)
`define VFM_RST_SHORT_MS   100
`define VFM_RST_LONG_MS    350
`define VFM_RST_MAX_MS     30000
`define VFM_STEP_MS        10

`endif

// >>> common/vfm_pkg.sv
package vfm_pkg;

    typedef enum logic [1:0] {
        VFM_SINGLE      = 2'h0,
        VFM_DOUBLE      = 2'h1,
        VFM_DIRECTIONAL = 2'h2
    } vfm_type_t;

    typedef struct packed {
        logic ctl1;
        logic ctl2;
        logic rb1;
        logic rb2;
        logic rst;
    } vfm_in_t;

    typedef struct packed {
        logic out1;
        logic out2;
        logic rb_err;
        logic dir_err;
        logic err_flag;
    } vfm_out_t;

endpackage : vfm_pkg

// >>> verif/vfm_top_chk.sv
`timescale 1ns/10ps
module vfm_top_chk
    import vfm_pkg::*;
#(
    parameter int TICK_CYC = 10
) (
    // Clock and reset.
    input wire logic              pclk,
    input wire logic              presetn,
    // APB slave.
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Valve pins and interrupt.
    input wire vfm_pkg::vfm_in_t  pins_in,
    input wire vfm_pkg::vfm_out_t pins_out,
    input wire logic              irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_dry_start;
        $rose(pins_in.ctl1) && !pins_in.rb1 ##1
            (pins_in.ctl1 && !pins_in.rb1) [*4];
    endsequence
    sequence s_err_held;
        (pins_out.rb_err || pins_out.dir_err) [*2];
    endsequence
    property p_dry_start;
        s_dry_start |-> ##[0:6] pins_out.rb_err;
    endproperty
    a_dry_start: assert property (p_dry_start)
        else $error("dry start gave no read-back error");
    property p_err_out;
        s_err_held |-> !pins_out.out1 && !pins_out.out2;
    endproperty
    a_err_out: assert property (p_err_out)
        else $error("output high with error pending");
    property p_ctl_low;
        (!pins_in.ctl1) [*7] |-> !pins_out.out1;
    endproperty
    a_ctl_low: assert property (p_ctl_low)
        else $error("output high with control low");
    property p_out_rise;
        $rose(pins_out.out1) |-> pins_in.rb1 && pins_in.ctl1;
    endproperty
    a_out_rise: assert property (p_out_rise)
        else $error("output rose without closed valve");
    property p_dir_src;
        $rose(pins_out.dir_err) |-> pins_in.ctl1 && pins_in.ctl2;
    endproperty
    a_dir_src: assert property (p_dir_src)
        else $error("directional error without both controls");
    property p_flag;
        s_err_held |-> pins_out.err_flag;
    endproperty
    a_flag: assert property (p_flag)
        else $error("error flag low with error high");
    property p_apb_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("no ready one cycle into access");
    property p_slverr;
        pslverr |-> pready && psel && penable;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("error response outside access");
endmodule : vfm_top_chk
bind vfm_top vfm_top_chk #(.TICK_CYC(TICK_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
    .pins_out(pins_out), .irq(irq));

// >>> verif/vfm_valve_model.sv
`timescale 1ns/10ps
module vfm_valve_model (
    // Clock.
    input  wire logic       pclk,
    // Coil and fault: 0 good, 1 slow, 2 stuck closed, 3 stuck open.
    input  wire logic       drive,
    input  wire logic [1:0] fault,
    // Feedback contact, high while the valve is closed.
    output logic            rb
);
    logic rb_q = 1'b1;
    int   wait_q = 0;
    assign rb = rb_q;
    always @(posedge pclk) begin
        wait_q <= (rb_q === drive) ? wait_q + 1 : 0;
        if (fault[1]) begin
            rb_q <= ~fault[0];
        end else if (rb_q === drive && wait_q >= (fault[0] ? 80 : 3)) begin
            rb_q <= ~drive;
        end
    end
endmodule : vfm_valve_model

// >>> verif/vfm_top_bench.sv
`timescale 1ns/10ps
`include "vfm_defines.svh"
module vfm_top_bench;
    import vfm_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, c1 = 1'b0, c2 = 1'b0, rs = 1'b0;
    logic        pready, pslverr, irq, rb1, rb2, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0]  f1 = 2'h0;
    vfm_in_t     pin;
    vfm_out_t    po;
    int          n_fail = 0;
    int          num_checks = 0;
    assign pin = {c1, c2, rb1, rb2, rs};
    always #5 pclk = ~pclk;
    vfm_top #(.TICK_CYC(10)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins_in(pin),
        .pins_out(po), .irq(irq));
    vfm_valve_model u_v1 (.pclk(pclk), .drive(po.out1), .fault(f1), .rb(rb1));
    vfm_valve_model u_v2 (.pclk(pclk), .drive(po.out2), .fault(2'h0),
        .rb(rb2));
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    task automatic conclude();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    task automatic drv(input logic a, input logic b, input int n);
        c1 <= a;
        c2 <= b;
        wt(n);
    endtask : drv
    task automatic pins(input logic [4:0] e);
        chk({27'h0, po}, {27'h0, e});
    endtask : pins
    initial begin
        wt(20000);
        n_fail++;
        conclude();
    end
    initial begin
        wt(6);
        presetn <= 1'b1;
        rdc(`VFM_ADDR_CTRL, 32'h20);
        rdc(`VFM_ADDR_TON, 32'h5);
        rdc(`VFM_ADDR_TOFF, 32'h5);
        rdc(12'h018, 32'h0);
        chk({31'h0, er}, 32'h1);
        wr(`VFM_ADDR_TON, 32'h3E8);
        rdc(`VFM_ADDR_TON, 32'h3E8);
        wr(`VFM_ADDR_TON, 32'h5);
        wr(`VFM_ADDR_IRQ_MASK, 32'h7);
        drv(1'b1, 1'b0, 20);
        pins(5'h10);
        wt(60);
        pins(5'h10);
        drv(1'b0, 1'b0, 80);
        pins(5'h00);
        apb(1'b0, `VFM_ADDR_IRQ_STAT, 32'h0);
        f1 <= 2'h3;
        wt(10);
        drv(1'b1, 1'b0, 12);
        pins(5'h05);
        chk({31'h0, irq}, 32'h1);
        rdc(`VFM_ADDR_STATUS, 32'h5);
        apb(1'b0, `VFM_ADDR_IRQ_STAT, 32'h0);
        chk(rd & 32'h2, 32'h2);
        rdc(`VFM_ADDR_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        f1 <= 2'h0;
        wr(`VFM_ADDR_IRQ_MASK, 32'h1);
        drv(1'b0, 1'b0, 20);
        pins(5'h00);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, `VFM_ADDR_IRQ_STAT, 32'h0);
        chk(rd & 32'h1, 32'h1);
        f1 <= 2'h1;
        drv(1'b1, 1'b0, 35);
        pins(5'h10);
        wt(35);
        pins(5'h05);
        chk({31'h0, irq}, 32'h0);
        f1 <= 2'h0;
        drv(1'b0, 1'b0, 20);
        drv(1'b1, 1'b0, 20);
        f1 <= 2'h1;
        drv(1'b0, 1'b0, 30);
        pins(5'h00);
        wt(40);
        pins(5'h05);
        wt(40);
        pins(5'h00);
        wr(`VFM_ADDR_TON, 32'h0);
        wr(`VFM_ADDR_TOFF, 32'h0);
        drv(1'b1, 1'b0, 100);
        pins(5'h10);
        drv(1'b0, 1'b0, 100);
        pins(5'h00);
        f1 <= 2'h0;
        wr(`VFM_ADDR_TON, 32'h5);
        wr(`VFM_ADDR_CTRL, 32'h28);
        drv(1'b1, 1'b0, 70);
        f1 <= 2'h2;
        wt(15);
        pins(5'h05);
        f1 <= 2'h0;
        drv(1'b0, 1'b0, 20);
        pins(5'h00);
        wr(`VFM_ADDR_CTRL, 32'h22);
        drv(1'b1, 1'b0, 20);
        pins(5'h18);
        drv(1'b1, 1'b1, 15);
        pins(5'h03);
        drv(1'b0, 1'b0, 20);
        pins(5'h00);
        wr(`VFM_ADDR_CTRL, 32'h24);
        f1 <= 2'h3;
        wt(10);
        drv(1'b1, 1'b0, 15);
        f1 <= 2'h0;
        drv(1'b0, 1'b0, 20);
        pins(5'h05);
        rs <= 1'b1;
        wt(50);
        rs <= 1'b0;
        wt(20);
        pins(5'h05);
        rs <= 1'b1;
        wt(120);
        rs <= 1'b0;
        wt(20);
        pins(5'h00);
        wr(`VFM_ADDR_CTRL, 32'h34);
        f1 <= 2'h3;
        wt(10);
        drv(1'b1, 1'b0, 15);
        f1 <= 2'h0;
        drv(1'b0, 1'b0, 20);
        pins(5'h05);
        rs <= 1'b1;
        wt(120);
        rs <= 1'b0;
        wt(20);
        pins(5'h05);
        rs <= 1'b1;
        wt(400);
        rs <= 1'b0;
        wt(20);
        pins(5'h00);
        wr(`VFM_ADDR_CTRL, 32'h21);
        drv(1'b0, 1'b1, 20);
        pins(5'h08);
        drv(1'b1, 1'b1, 20);
        pins(5'h18);
        drv(1'b0, 1'b0, 20);
        pins(5'h00);
        conclude();
    end
endmodule : vfm_top_bench
